// >>> common/hvc_pkg.sv
// Package: register map, field layout and widths for the horizontal crop block
package hvc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// Printed offsets are not all multiples of four, so they are kept as word indices
	localparam logic [7:0] HVC_IDX_START_LO = 8'h36;
	localparam logic [7:0] HVC_IDX_START_HI = 8'h37;
	localparam logic [7:0] HVC_IDX_STOP_LO  = 8'h38;
	localparam logic [7:0] HVC_IDX_STOP_HI  = 8'h39;
	localparam logic [7:0] HVC_IDX_PORT_SEL = 8'h3e;
	localparam int         HVC_ADDR_W       = 12;
	localparam int         HVC_WORD_LSB     = 2;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int         HVC_COL_W       = 13;
	localparam int         HVC_LO_W        = 8;
	localparam int         HVC_HI_W        = 5;
	localparam int         HVC_EN_BIT      = 7;
	localparam int         HVC_NPORT       = 2;
	localparam logic [7:0] HVC_REG_RESET   = 8'h00;
	localparam logic [12:0] HVC_COL_ZERO   = 13'h0000;
	localparam logic [12:0] HVC_COL_ONE    = 13'h0001;

endpackage

// >>> rtl/hvc_col_counter.sv
// Column counter: numbers active pixels of each line from zero
`timescale 1ns/1ps
module hvc_col_counter
	import hvc_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 pixel_valid,
	output logic [HVC_COL_W-1:0]      col
);
	logic                 valid_d_r;
	logic [HVC_COL_W-1:0] run_r;
	logic [HVC_COL_W-1:0] run_nxt;
	wire                  line_start = pixel_valid & ~valid_d_r;

	// ----------------------------------------
	// Count
	// ----------------------------------------
	// Restart on the rising edge of data-enable, so the first active pixel is column 0
	assign col     = line_start ? HVC_COL_ZERO : run_r;
	assign run_nxt = col + HVC_COL_ONE;

	// Running count only advances on active pixels
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			valid_d_r <= 1'b0;
			run_r     <= HVC_COL_ZERO;
		end else begin
			valid_d_r <= pixel_valid;
			if (pixel_valid) begin
				run_r <= run_nxt;
			end
		end
	end
endmodule

// >>> rtl/hvc_port_regs.sv
// Per-port crop settings: enable, start and stop columns
`timescale 1ns/1ps
module hvc_port_regs
	import hvc_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 wr_start_lo,
	input  wire logic                 wr_start_hi,
	input  wire logic                 wr_stop_lo,
	input  wire logic                 wr_stop_hi,
	input  wire logic [7:0]           wdata,
	output logic                      trim_on,
	output logic [HVC_COL_W-1:0]      first_col,
	output logic [HVC_COL_W-1:0]      last_col
);
	logic [7:0] start_lo_r;
	logic [7:0] start_hi_r;
	logic [7:0] stop_lo_r;
	logic [7:0] stop_hi_r;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// All settings clear on reset, so cropping starts disabled
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			start_lo_r <= HVC_REG_RESET;
			start_hi_r <= HVC_REG_RESET;
			stop_lo_r  <= HVC_REG_RESET;
			stop_hi_r  <= HVC_REG_RESET;
		end else begin
			if (wr_start_lo) start_lo_r <= wdata;
			if (wr_start_hi) start_hi_r <= wdata;
			if (wr_stop_lo)  stop_lo_r  <= wdata;
			if (wr_stop_hi)  stop_hi_r  <= wdata;
		end
	end

	// Field assembly; reserved bits are stored but ignored here
	assign trim_on   = start_hi_r[HVC_EN_BIT];
	assign first_col = {start_hi_r[HVC_HI_W-1:0], start_lo_r};
	assign last_col  = {stop_hi_r[HVC_HI_W-1:0], stop_lo_r};
endmodule

// >>> rtl/hvc_crop_top.sv
// Horizontal crop stage with APB register access and two port copies
`timescale 1ns/1ps
module hvc_crop_top
	import hvc_pkg::*;
#(
	parameter int PIX_W = 24
)(
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [HVC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 pixel_valid_0,
	input  wire logic [PIX_W-1:0]     pixel_in_0,
	input  wire logic                 pixel_valid_1,
	input  wire logic [PIX_W-1:0]     pixel_in_1,
	output logic                      pixel_valid_out_0,
	output logic [PIX_W-1:0]          pixel_out_0,
	output logic                      pixel_valid_out_1,
	output logic [PIX_W-1:0]          pixel_out_1
);
	localparam logic [PIX_W-1:0] BLANK = '0;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Index is the eight bits above the byte lane; higher address bits must be zero,
	// otherwise the map would alias every 1 KiB
	wire [7:0] idx      = paddr[HVC_WORD_LSB+HVC_LO_W-1:HVC_WORD_LSB];
	wire       idx_top0 = (paddr[HVC_ADDR_W-1:HVC_WORD_LSB+HVC_LO_W] == '0);
	wire       aligned  = (paddr[HVC_WORD_LSB-1:0] == 2'b00) && idx_top0;
	wire       sel_slo  = aligned && (idx == HVC_IDX_START_LO);
	wire       sel_shi  = aligned && (idx == HVC_IDX_START_HI);
	wire       sel_plo  = aligned && (idx == HVC_IDX_STOP_LO);
	wire       sel_phi  = aligned && (idx == HVC_IDX_STOP_HI);
	wire       sel_port = aligned && (idx == HVC_IDX_PORT_SEL);
	wire       mapped   = sel_slo | sel_shi | sel_plo | sel_phi | sel_port;
	// Access phase lasts one cycle: pready is registered high in the cycle after setup, so no wait states
	wire       access   = psel & penable;
	wire       wr_en    = access & pwrite & mapped;

	logic port_sel_r;

	// Per-port copies of settings and stream outputs
	logic                 trim_on   [HVC_NPORT];
	logic [HVC_COL_W-1:0] first_col [HVC_NPORT];
	logic [HVC_COL_W-1:0] last_col  [HVC_NPORT];
	logic [HVC_COL_W-1:0] col       [HVC_NPORT];
	logic                 vin       [HVC_NPORT];
	logic [PIX_W-1:0]     din       [HVC_NPORT];
	logic                 vout_r    [HVC_NPORT];
	logic [PIX_W-1:0]     dout_r    [HVC_NPORT];

	assign vin[0] = pixel_valid_0;
	assign vin[1] = pixel_valid_1;
	assign din[0] = pixel_in_0;
	assign din[1] = pixel_in_1;

	// ----------------------------------------
	// Per-port datapath
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < HVC_NPORT; g++) begin : g_port
			// Writes land only in the copy of the currently selected port
			wire hit = wr_en && (port_sel_r == 1'(g));
			wire keep;

			hvc_port_regs u_regs (
				.core_clk    (core_clk),
				.sys_rst     (sys_rst),
				.wr_start_lo (hit & sel_slo),
				.wr_start_hi (hit & sel_shi),
				.wr_stop_lo  (hit & sel_plo),
				.wr_stop_hi  (hit & sel_phi),
				.wdata       (pwdata[7:0]),
				.trim_on     (trim_on[g]),
				.first_col   (first_col[g]),
				.last_col    (last_col[g])
			);

			hvc_col_counter u_cnt (
				.core_clk    (core_clk),
				.sys_rst     (sys_rst),
				.pixel_valid (vin[g]),
				.col         (col[g])
			);

			// Inside the window when start <= col <= stop; stop itself is forwarded
			assign keep = ~trim_on[g]
				| ((col[g] >= first_col[g])
				& (col[g] <= last_col[g]));

			// One register stage; outside the window drive blanking with valid low
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					vout_r[g] <= 1'b0;
					dout_r[g] <= BLANK;
				end else begin
					vout_r[g] <= vin[g] & keep;
					dout_r[g] <= keep ? din[g] : BLANK;
				end
			end
		end
	endgenerate

	assign pixel_valid_out_0 = vout_r[0];
	assign pixel_out_0       = dout_r[0];
	assign pixel_valid_out_1 = vout_r[1];
	assign pixel_out_1       = dout_r[1];

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Reads show the selected port's copy; reserved bits read as zero
	wire       ps      = port_sel_r;
	wire [7:0] rd_slo  = first_col[ps][HVC_LO_W-1:0];
	wire [7:0] rd_shi  = {trim_on[ps], 2'b00, first_col[ps][HVC_COL_W-1:HVC_LO_W]};
	wire [7:0] rd_plo  = last_col[ps][HVC_LO_W-1:0];
	wire [7:0] rd_phi  = {3'b000, last_col[ps][HVC_COL_W-1:HVC_LO_W]};
	wire [7:0] rd_mux  = sel_slo  ? rd_slo :
	                     sel_shi  ? rd_shi :
	                     sel_plo  ? rd_plo :
	                     sel_phi  ? rd_phi :
	                     sel_port ? {7'h00, port_sel_r} : 8'h00;

	// ----------------------------------------
	// APB response and port select
	// ----------------------------------------
	// Answer registered so outputs come from flops; unmapped access errors out
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			port_sel_r <= 1'b0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_mux} : 32'h0000_0000;
			if (wr_en && sel_port) begin
				port_sel_r <= pwdata[0];
			end
		end
	end
endmodule

// >>> dv/hvc_crop_properties.sv
// Checker: bus and pixel stream properties of the crop block
`timescale 1ns/1ps
module hvc_crop_properties
	import hvc_pkg::*;
#(
	parameter int PIX_W = 24
)(
	input wire logic             core_clk,
	input wire logic             sys_rst,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             pixel_valid_0,
	input wire logic [PIX_W-1:0] pixel_in_0,
	input wire logic             pixel_valid_1,
	input wire logic [PIX_W-1:0] pixel_in_1,
	input wire logic             pixel_valid_out_0,
	input wire logic [PIX_W-1:0] pixel_out_0,
	input wire logic             pixel_valid_out_1,
	input wire logic [PIX_W-1:0] pixel_out_1
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Bus answers with no wait state
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	access_only_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// Cropping only removes pixels, never invents them
	kept_in0_a: assert property (pixel_valid_out_0 |-> $past(pixel_valid_0))
		else $error("port 0 valid without input");
	kept_in1_a: assert property (!$past(pixel_valid_1) |-> !pixel_valid_out_1)
		else $error("port 1 valid without input");
	// Forwarded pixels keep their data
	kept_data0_a: assert property (pixel_valid_out_0 |-> pixel_out_0 == $past(pixel_in_0))
		else $error("port 0 data changed");
	kept_data1_a: assert property (pixel_valid_out_1 |-> pixel_out_1 == $past(pixel_in_1))
		else $error("port 1 data changed");
	cover property (pslverr);
	cover property ($past(pixel_valid_0) && !pixel_valid_out_0);
	cover property (pixel_valid_out_1 && !pixel_valid_out_0);
endmodule
bind hvc_crop_top hvc_crop_properties #(.PIX_W(PIX_W)) hvc_crop_properties_inst (
	.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pixel_valid_0(pixel_valid_0), .pixel_in_0(pixel_in_0),
	.pixel_valid_1(pixel_valid_1), .pixel_in_1(pixel_in_1),
	.pixel_valid_out_0(pixel_valid_out_0), .pixel_out_0(pixel_out_0),
	.pixel_valid_out_1(pixel_valid_out_1), .pixel_out_1(pixel_out_1));

// >>> dv/hvc_src_model.sv
// Partner: video source emitting one line of numbered pixels
`timescale 1ns/1ps
module hvc_src_model (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        go,
	input wire logic [12:0] len,
	output logic            pixel_valid,
	output logic [23:0]     pixel,
	output logic            busy
);
	logic [12:0] col_r;
	// Pixel value is column plus one; blank data toggles so it never looks settled
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy <= 1'b0; pixel_valid <= 1'b0; pixel <= 24'h0; col_r <= 13'h0;
		end else if (busy && col_r == len) begin
			busy <= 1'b0; pixel_valid <= 1'b0; pixel <= ~pixel;
		end else if (busy) begin
			pixel <= {11'h0, col_r} + 24'h1; col_r <= col_r + 13'h1;
		end else if (go) begin
			busy <= 1'b1; pixel_valid <= 1'b1; pixel <= 24'h1; col_r <= 13'h1;
		end else pixel <= ~pixel;
	end
endmodule

// >>> dv/horizontal_video_crop_tb_top.sv
// Testbench: register access and horizontal crop scenarios
`timescale 1ns/1ps
module horizontal_video_crop_tb_top;
	import hvc_pkg::*;
	logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, busy, v, o0v, o1v;
	logic [23:0] p, o0, o1;
	logic [12:0] len = 13'h0, n [2];
	logic [23:0] f [2], l [2];
	int          err_count = 0, comparisons = 0;
	always #2 core_clk = ~core_clk;
	// Both ports see the same line so their settings can be told apart
	hvc_src_model hvc_src_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .go(go),
		.len(len), .pixel_valid(v), .pixel(p), .busy(busy));
	hvc_crop_top hvc_crop_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pixel_valid_0(v), .pixel_in_0(p),
		.pixel_valid_1(v), .pixel_in_1(p), .pixel_valid_out_0(o0v), .pixel_out_0(o0),
		.pixel_valid_out_1(o1v), .pixel_out_1(o1));
	// ----------------------------------------
	// Output monitor: count, first and last kept pixel
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (go) begin n[0] <= 0; n[1] <= 0; end
		if (o0v) begin if (n[0] == 0) f[0] <= o0; l[0] <= o0; n[0] <= n[0] + 1; end
		if (o1v) begin if (n[1] == 0) f[1] <= o1; l[1] <= o1; n[1] <= n[1] + 1; end
	end
	task results;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One transfer; waits for pready, takes data at that edge
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int i;
		@(posedge core_clk);
		psel <= 1; pwrite <= w; paddr <= {2'h0, idx, 2'h0}; pwdata <= {24'h0, wd};
		@(posedge core_clk) penable <= 1;
		i = 0;
		do begin @(posedge core_clk); i++; end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin err_count++; results; end
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] wd); apb(1, idx, wd); endtask
	task rdchk(input logic [7:0] idx, input logic [31:0] exp);
		apb(0, idx, 8'h0); chk(rd, exp); chk(32'(er), 0);
	endtask
	task line(input logic [12:0] ln);
		int i;
		@(posedge core_clk) begin go <= 1; len <= ln; end
		@(posedge core_clk) go <= 0;
		i = 0;
		do begin @(posedge core_clk); i++; end while (busy === 1'b1 && i < 9000);
		if (i >= 9000) begin err_count++; results; end
		repeat (3) @(posedge core_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		for (int i = 0; i < 4; i++) rdchk(HVC_IDX_START_LO + 8'(i), 0);
		line(8); chk(32'(n[0]), 8); chk(32'(l[0]), 8);
	endtask
	task t_window;
		wr(HVC_IDX_START_LO, 8'h01); wr(HVC_IDX_START_HI, 8'he1);
		wr(HVC_IDX_STOP_LO, 8'h03); wr(HVC_IDX_STOP_HI, 8'he1);
		rdchk(HVC_IDX_START_HI, 32'h81); rdchk(HVC_IDX_STOP_HI, 32'h01);
		line(13'h0106); chk(32'(n[0]), 3); chk(32'(n[1]), 32'h106);
		chk(32'(f[0]), 32'h102); chk(32'(l[0]), 32'h104);
	endtask
	task t_port;
		wr(HVC_IDX_PORT_SEL, 1); wr(HVC_IDX_START_LO, 0); wr(HVC_IDX_START_HI, 8'h80);
		line(5); chk(32'(n[1]), 1); chk(32'(f[1]), 1); chk(32'(n[0]), 0);
		rdchk(HVC_IDX_START_HI, 32'h80); wr(HVC_IDX_PORT_SEL, 0);
		rdchk(HVC_IDX_START_HI, 32'h81); apb(0, 8'h40, 8'h0);
		chk(32'(er), 1); chk(rd, 0);
	endtask
	task t_off;
		wr(HVC_IDX_START_HI, 8'h01); line(4); chk(32'(n[0]), 4); chk(32'(l[0]), 4);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 0;
		t_reset;
		t_window;
		t_port;
		t_off;
		results;
	end
endmodule
